// [s2m_channel_ctrl.sv]
/*
 * stream-to-memory channel control: control register over an Avalon-MM
 * slave, write burst shaping, descriptor completed-flag handling, halted
 * status, completion coalescing, idle delay timer and the interrupt output.
 * assumes: engine events are one-cycle pulses synchronous to core_clk;
 * configuration straps are static levels.
 */
// The Avalon-MM register port and the placing of the registers are this design's own decisions.
// Summary of operation
// - fixed bit makes write bursts fixed-address
// - fixed-address bursts capped at sixteen beats
// - multichannel mode ignores the fixed bit
// - ring repeat ignores descriptor completed flag
// - ring repeat void in multichannel or direct
// - bits eleven to five read zero
// - bit twelve gates completion interrupt
// - bit thirteen gates delay interrupt, gather only
// - bit fourteen gates error interrupt
// - bit fifteen reserved, reads zero
// - run bit starts channel, clears halted
// - completion counter from coalesce count, minimum one
// - delay timer: packet end, times 125
`timescale 1ns/1ps
`default_nettype none
module s2m_channel_ctrl
	import s2m_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// avalon-mm slave
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// configuration straps
	input wire logic sg_present,
	input wire logic multichannel_mode,
	// engine events
	input wire logic engine_idle,
	input wire logic completion_event,
	input wire logic desc_irq_flag,
	input wire logic fault_event,
	input wire logic packet_start,
	input wire logic packet_end,
	// write burst shaping
	input wire logic [7:0] req_len,
	output logic [1:0] wr_burst,
	output logic [7:0] wr_len,
	// channel control
	output logic run_stop_control,
	output logic halted,
	output logic ignore_completed,
	output logic irq
);
	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	typedef enum logic [0:0] {
		BUS_IDLE = 1'b0,
		BUS_ANSWER = 1'b1
	} s2m_bus_state_t;

	s2m_bus_state_t bus_state;
	s2m_bus_state_t next_bus_state;
	logic fixed_addr;
	logic ring_repeat;
	logic cpl_en;
	logic dly_en;
	logic fault_en;
	logic [7:0] coalesce_count;
	logic [7:0] idle_timeout;
	logic [2:0] irq_status;
	logic [2:0] irq_enable;

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	wire access = avs_read | avs_write;
	wire ack = (bus_state == BUS_ANSWER);
	wire wr_fire = avs_write & ack;
	wire rd_load = avs_read & ~ack;
	wire hit_ctrl = (avs_address == OFS_CONTROL);
	wire hit_stat = (avs_address == OFS_IRQ_STATUS);
	wire hit_clr = (avs_address == OFS_IRQ_CLEAR);
	wire hit_en = (avs_address == OFS_IRQ_ENABLE);
	wire wr_ctrl = wr_fire & hit_ctrl;
	wire [3:0] be = avs_byteenable;
	wire ctrl_lane0 = wr_ctrl & be[0];
	wire ctrl_lane1 = wr_ctrl & be[1];
	wire [7:0] wr_coalesce_value = avs_writedata[LSB_COALESCE +: 8];
	wire [7:0] wr_timeout_value = avs_writedata[LSB_IDLE_TIMEOUT +: 8];
	wire soft_reset = ctrl_lane0 & avs_writedata[BIT_SOFT_RESET];
	// a zero count would fire on every event, so such a write is dropped
	wire wr_coalesce = wr_ctrl & be[2] & (wr_coalesce_value != 8'h00);
	wire wr_timeout = wr_ctrl & be[3];

	// one wait state: every access is answered at its second edge
	assign avs_waitrequest = access & ~ack;

	// ----------------------------------------------------------------
	// bus handshake
	// ----------------------------------------------------------------
	always_comb begin
		next_bus_state = bus_state;
		case (bus_state)
			BUS_IDLE: begin
				if (access)
					next_bus_state = BUS_ANSWER;
			end
			BUS_ANSWER: begin
				next_bus_state = BUS_IDLE;
			end
			default: begin
				next_bus_state = BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			bus_state <= BUS_IDLE;
		else
			bus_state <= next_bus_state;
	end

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	// reserved bits 11:5 and 15 stay zero, bit 1 reads one
	wire [31:0] ctrl_value = {idle_timeout, coalesce_count,
		1'b0,
		fault_en, dly_en, cpl_en,
		7'h00,
		ring_repeat, fixed_addr, 1'b0, 1'b1, run_stop_control};
	wire [31:0] stat_value = {15'h0000, halted, 13'h0000, irq_status};
	wire [31:0] en_value = {29'h00000000, irq_enable};
	wire [31:0] read_mux = hit_ctrl ? ctrl_value :
		hit_stat ? stat_value :
		hit_en ? en_value : 32'h00000000;

	// loaded in the waiting cycle so it stands at the answering edge
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			avs_readdata <= 32'h00000000;
		else if (rd_load)
			avs_readdata <= read_mux;
	end

	// ----------------------------------------------------------------
	// run/stop control
	// ----------------------------------------------------------------
	// an error stops the channel even against a write in the same cycle
	wire next_run = fault_event ? 1'b0 :
		ctrl_lane0 ? avs_writedata[BIT_RUN] : run_stop_control;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			run_stop_control <= 1'b0;
		else if (soft_reset)
			run_stop_control <= 1'b0;
		else
			run_stop_control <= next_run;
	end

	// ----------------------------------------------------------------
	// address mode and descriptor ring repeat
	// ----------------------------------------------------------------
	wire next_fixed_addr = ctrl_lane0 ? avs_writedata[BIT_FIXED_ADDR] : fixed_addr;
	wire next_ring_repeat = ctrl_lane0 ? avs_writedata[BIT_RING_REPEAT] : ring_repeat;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			fixed_addr <= 1'b0;
		else if (soft_reset)
			fixed_addr <= 1'b0;
		else
			fixed_addr <= next_fixed_addr;
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			ring_repeat <= 1'b0;
		else if (soft_reset)
			ring_repeat <= 1'b0;
		else
			ring_repeat <= next_ring_repeat;
	end

	// ----------------------------------------------------------------
	// interrupt enables of the control register
	// ----------------------------------------------------------------
	wire next_cpl_en = ctrl_lane1 ? avs_writedata[BIT_CPL_IRQ_EN] : cpl_en;
	wire next_dly_en = ctrl_lane1 ? avs_writedata[BIT_DLY_IRQ_EN] : dly_en;
	wire next_fault_en = ctrl_lane1 ? avs_writedata[BIT_FAULT_IRQ_EN] : fault_en;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cpl_en <= 1'b0;
			dly_en <= 1'b0;
			fault_en <= 1'b0;
		end else if (soft_reset) begin
			cpl_en <= 1'b0;
			dly_en <= 1'b0;
			fault_en <= 1'b0;
		end else begin
			cpl_en <= next_cpl_en;
			dly_en <= next_dly_en;
			fault_en <= next_fault_en;
		end
	end

	// ----------------------------------------------------------------
	// coalesce count and idle timeout
	// ----------------------------------------------------------------
	// the coalescer reloads from this, so it must carry the value being written
	wire [7:0] next_coalesce_count = soft_reset ? RST_COALESCE :
		wr_coalesce ? wr_coalesce_value : coalesce_count;
	wire [7:0] next_idle_timeout = soft_reset ? RST_IDLE_TIMEOUT :
		wr_timeout ? wr_timeout_value : idle_timeout;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			coalesce_count <= RST_COALESCE;
		else
			coalesce_count <= next_coalesce_count;
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			idle_timeout <= RST_IDLE_TIMEOUT;
		else
			idle_timeout <= next_idle_timeout;
	end

	// ----------------------------------------------------------------
	// halted status
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			halted <= 1'b1;
		else if (run_stop_control)
			halted <= 1'b0;
		else if (engine_idle)
			halted <= 1'b1;
	end

	// ----------------------------------------------------------------
	// write burst shaping and descriptor handling
	// ----------------------------------------------------------------
	wire fixed_active = fixed_addr & ~multichannel_mode;
	wire [7:0] capped_len = (req_len > FIXED_MAX_LEN) ? FIXED_MAX_LEN : req_len;
	wire [1:0] next_wr_burst = fixed_active ? 2'h0 : 2'h1;
	wire [7:0] next_wr_len = fixed_active ? capped_len : req_len;
	wire next_ignore = ring_repeat & sg_present & ~multichannel_mode;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wr_burst <= 2'h1;
			wr_len <= 8'h00;
		end else begin
			wr_burst <= next_wr_burst;
			wr_len <= next_wr_len;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			ignore_completed <= 1'b0;
		else
			ignore_completed <= next_ignore;
	end

	// ----------------------------------------------------------------
	// interrupt sources
	// ----------------------------------------------------------------
	wire cpl_qual = completion_event & desc_irq_flag;
	wire cpl_hit;
	wire dly_hit;

	s2m_coalesce u_coalesce (
		.core_clk(core_clk),
		.rst(rst),
		.count(next_coalesce_count),
		.reload(wr_coalesce | soft_reset),
		.event_in(cpl_qual & sg_present),
		.hit(cpl_hit)
	);

	s2m_delay_timer u_delay (
		.core_clk(core_clk),
		.rst(rst),
		.timeout(idle_timeout),
		.enable(sg_present & ~soft_reset),
		.packet_start(packet_start),
		.packet_end(packet_end),
		.expired(dly_hit)
	);

	// ----------------------------------------------------------------
	// interrupt status, enable and output
	// ----------------------------------------------------------------
	wire cpl_event = sg_present ? cpl_hit : cpl_qual;
	wire [2:0] events = {fault_event, dly_hit, cpl_event};
	wire [2:0] clr_bits = (wr_fire & hit_clr & be[0]) ? avs_writedata[2:0] : 3'h0;
	wire [2:0] ctrl_gate = {fault_en, dly_en & sg_present, cpl_en};
	// set wins over a clear in the same cycle
	wire [2:0] next_irq_status = (irq_status & ~clr_bits) | events;
	wire wr_irq_enable = wr_fire & hit_en & be[0];
	wire [2:0] next_irq_enable = wr_irq_enable ? avs_writedata[2:0] : irq_enable;
	wire next_irq = |(irq_status & irq_enable & ctrl_gate);

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			irq_status <= 3'h0;
		else
			irq_status <= next_irq_status;
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			irq_enable <= RST_IRQ_ENABLE;
		else
			irq_enable <= next_irq_enable;
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			irq <= 1'b0;
		else
			irq <= next_irq;
	end
endmodule
`default_nettype wire

// [s2m_channel_ctrl_sva.sv]
/* checker for the channel control ports.
   assumes: bound to s2m_channel_ctrl, single clock domain. */
`timescale 1ns/1ps
`default_nettype none
module s2m_channel_ctrl_sva (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// watched ports
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic sg_present,
	input wire logic multichannel_mode,
	input wire logic [7:0] req_len,
	input wire logic [1:0] wr_burst,
	input wire logic [7:0] wr_len,
	input wire logic run_stop_control,
	input wire logic halted,
	input wire logic ignore_completed
);
	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);
	a_fixed_len_cap: assert property (
		wr_burst == 2'h0 |-> wr_len <= 8'h0f) else $error("fixed burst too long");
	a_len_follow: assert property (
		1'b1 |=> wr_len == ((wr_burst == 2'h0 && $past(req_len) > 8'h0f) ?
		8'h0f : $past(req_len))) else $error("burst length wrong");
	a_multi_incr: assert property (
		multichannel_mode |=> wr_burst == 2'h1) else $error("fixed burst in multichannel");
	a_ring_multi: assert property (
		multichannel_mode |=> !ignore_completed) else $error("ring repeat in multichannel");
	a_ring_direct: assert property (
		!sg_present |=> !ignore_completed) else $error("ring repeat in direct mode");
	a_halt_clear: assert property (
		$rose(run_stop_control) |=> !halted) else $error("halted not cleared");
	a_bus_wait: assert property (
		(avs_read || avs_write) && !$past(avs_read || avs_write) |->
		avs_waitrequest ##1 !avs_waitrequest) else $error("bus answer late");
	a_rdata_hold: assert property (
		!avs_read |=> $stable(avs_readdata)) else $error("read data moved");
endmodule
`default_nettype wire

// [s2m_coalesce.sv]
/*
 * completion coalescing counter: counts completion events down from the
 * programmed count and pulses when it reaches zero, then reloads.
 * assumes: count is never zero; reload pulses when software writes it.
 */
`timescale 1ns/1ps
`default_nettype none
module s2m_coalesce
	import s2m_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// control
	input wire logic [7:0] count,
	input wire logic reload,
	// events
	input wire logic event_in,
	output logic hit
);
	logic [7:0] remain;
	wire last_one = (remain <= 8'h01);

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			remain <= RST_COALESCE;
			hit <= 1'b0;
		end else begin
			hit <= event_in & last_one;
			if (event_in)
				remain <= last_one ? count : remain - 8'h01;
			else if (reload)
				remain <= count;
		end
	end
endmodule
`default_nettype wire

// [s2m_delay_timer.sv]
/*
 * idle delay timer: starts at packet end, stops and clears on packet start, expires
 * after timeout times 125 clock periods; a timeout of zero disables it.
 * assumes: packet_start and packet_end are one-cycle pulses.
 */
`timescale 1ns/1ps
`default_nettype none
module s2m_delay_timer
	import s2m_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// control
	input wire logic [7:0] timeout,
	input wire logic enable,
	// packet framing
	input wire logic packet_start,
	input wire logic packet_end,
	// expiry
	output logic expired
);
	logic running;
	logic [6:0] prescale;
	logic [7:0] units;
	wire unit_tick = running & (prescale == TIMEOUT_UNIT_CYCLES - 7'h01);
	wire reach = unit_tick & (units + 8'h01 == timeout);
	wire active = enable & (timeout != 8'h00);

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			running <= 1'b0;
			prescale <= 7'h00;
			units <= 8'h00;
			expired <= 1'b0;
		end else begin
			expired <= reach & active;
			if (packet_start | ~active | reach) begin
				running <= 1'b0;
				prescale <= 7'h00;
				units <= 8'h00;
			end else if (packet_end) begin
				running <= 1'b1;
				prescale <= 7'h00;
				units <= 8'h00;
			end else if (running) begin
				prescale <= unit_tick ? 7'h00 : prescale + 7'h01;
				units <= unit_tick ? units + 8'h01 : units;
			end
		end
	end
endmodule
`default_nettype wire

// [s2m_engine_model.sv]
/* engine model: turns bench commands into one-cycle engine event pulses.
   assumes: cmd is held for one core_clk cycle; the engine is always idle. */
`timescale 1ns/1ps
`default_nettype none
module s2m_engine_model (
	// clock and command
	input wire logic core_clk,
	input wire logic [2:0] cmd,
	// engine events
	output logic engine_idle,
	output logic completion_event,
	output logic desc_irq_flag,
	output logic fault_event,
	output logic packet_start,
	output logic packet_end
);
	// ----------------------------------------------------------------
	// event pulses
	// ----------------------------------------------------------------
	assign engine_idle = 1'b1;
	always_ff @(posedge core_clk) begin
		completion_event <= (cmd == 3'h1) || (cmd == 3'h5);
		desc_irq_flag <= cmd == 3'h1;
		fault_event <= cmd == 3'h2;
		packet_start <= cmd == 3'h3;
		packet_end <= cmd == 3'h4;
	end
endmodule
`default_nettype wire

// [s2m_pkg.sv]
/*
 * package for the stream-to-memory channel control block: register offsets,
 * control field positions, reset values and counts.
 * assumes: included before every other file of the block.
 */
`default_nettype none
package s2m_pkg;
	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CONTROL = 8'h30;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h40;
	localparam logic [7:0] OFS_IRQ_CLEAR = 8'h44;
	localparam logic [7:0] OFS_IRQ_ENABLE = 8'h48;

	// ----------------------------------------------------------------
	// control field positions
	// ----------------------------------------------------------------
	localparam int BIT_RUN = 0;
	localparam int BIT_ONE = 1;
	localparam int BIT_SOFT_RESET = 2;
	localparam int BIT_FIXED_ADDR = 3;
	localparam int BIT_RING_REPEAT = 4;
	localparam int BIT_CPL_IRQ_EN = 12;
	localparam int BIT_DLY_IRQ_EN = 13;
	localparam int BIT_FAULT_IRQ_EN = 14;
	localparam int LSB_COALESCE = 16;
	localparam int LSB_IDLE_TIMEOUT = 24;

	// ----------------------------------------------------------------
	// interrupt status positions
	// ----------------------------------------------------------------
	localparam int IRQ_CPL = 0;
	localparam int IRQ_DLY = 1;
	localparam int IRQ_FAULT = 2;
	localparam int IRQ_HALTED = 16;

	// ----------------------------------------------------------------
	// reset values and counts
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_COALESCE = 8'h01;
	localparam logic [7:0] RST_IDLE_TIMEOUT = 8'h00;
	localparam logic [2:0] RST_IRQ_ENABLE = 3'h7;
	localparam logic [6:0] TIMEOUT_UNIT_CYCLES = 7'h7d;
	localparam logic [7:0] FIXED_MAX_LEN = 8'h0f;
endpackage
`default_nettype wire

// [tb_top.sv]
/* testbench for the channel control block.
   assumes: s2m_pkg, design, engine model and checker compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import s2m_pkg::*;
	logic core_clk, rst, avs_read, avs_write, avs_waitrequest, sg_present;
	logic multichannel_mode, engine_idle, completion_event, desc_irq_flag;
	logic fault_event, packet_start, packet_end, run_stop_control, halted;
	logic ignore_completed, irq;
	logic [7:0] avs_address, req_len, wr_len;
	logic [31:0] avs_writedata, avs_readdata, rdat;
	logic [3:0] avs_byteenable;
	logic [2:0] cmd;
	logic [1:0] wr_burst;
	int err_count, cmp_count;
	s2m_channel_ctrl u_s2m_channel_ctrl (
		.core_clk(core_clk),
		.rst(rst),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.sg_present(sg_present),
		.multichannel_mode(multichannel_mode),
		.engine_idle(engine_idle),
		.completion_event(completion_event),
		.desc_irq_flag(desc_irq_flag),
		.fault_event(fault_event),
		.packet_start(packet_start),
		.packet_end(packet_end),
		.req_len(req_len),
		.wr_burst(wr_burst),
		.wr_len(wr_len),
		.run_stop_control(run_stop_control),
		.halted(halted),
		.ignore_completed(ignore_completed),
		.irq(irq)
	);
	s2m_engine_model u_s2m_engine_model (
		.core_clk(core_clk),
		.cmd(cmd),
		.engine_idle(engine_idle),
		.completion_event(completion_event),
		.desc_irq_flag(desc_irq_flag),
		.fault_event(fault_event),
		.packet_start(packet_start),
		.packet_end(packet_end)
	);
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task finish_test;
		$display("errors %0d compares %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		cmp_count++;
		if (s !== e) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task c1(input string nm, input logic e, input logic s);
		chk(nm, {31'h0, e}, {31'h0, s});
	endtask
	task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		do begin
			@(posedge core_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 64);
		rdat = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		repeat (2) @(posedge core_clk);
		if (n >= 64) begin
			err_count++;
			finish_test;
		end
	endtask
	task rc(input string nm, input logic [7:0] a, input logic [31:0] e);
		acc(1'b0, a, 32'h0);
		chk(nm, e, rdat);
	endtask
	task ev(input logic [2:0] k);
		cmd <= k;
		@(posedge core_clk);
		cmd <= 3'h0;
		repeat (5) @(posedge core_clk);
	endtask
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	initial begin
		rst = 1'b1;
		{avs_read, avs_write, cmd, multichannel_mode} = '0;
		{avs_address, avs_writedata} = '0;
		avs_byteenable = 4'hf;
		sg_present = 1'b1;
		req_len = 8'h20;
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		rc("ctrl", OFS_CONTROL, 32'h00010002);
		rc("enable", OFS_IRQ_ENABLE, 32'h7);
		rc("unmapped", 8'h10, 32'h0);
		acc(1'b1, OFS_CONTROL, 32'h0102ffd9);
		rc("ctrl", OFS_CONTROL, 32'h0102701b);
		c1("halted", 1'b0, halted);
		c1("ignore", 1'b1, ignore_completed);
		chk("burst", 32'h0, {30'h0, wr_burst});
		chk("len", 32'h0f, {24'h0, wr_len});
		multichannel_mode <= 1'b1;
		repeat (2) @(posedge core_clk);
		chk("burst", 32'h1, {30'h0, wr_burst});
		chk("len", 32'h20, {24'h0, wr_len});
		c1("ignore", 1'b0, ignore_completed);
		multichannel_mode <= 1'b0;
		acc(1'b1, OFS_CONTROL, 32'h0100701b);
		rc("ctrl", OFS_CONTROL, 32'h0102701b);
		ev(3'h1);
		rc("status", OFS_IRQ_STATUS, 32'h0);
		ev(3'h1);
		rc("status", OFS_IRQ_STATUS, 32'h1);
		c1("irq", 1'b1, irq);
		acc(1'b1, OFS_IRQ_CLEAR, 32'h7);
		c1("irq", 1'b0, irq);
		acc(1'b1, OFS_CONTROL, 32'h0101601b);
		ev(3'h1);
		rc("status", OFS_IRQ_STATUS, 32'h1);
		c1("irq", 1'b0, irq);
		acc(1'b1, OFS_IRQ_CLEAR, 32'h7);
		acc(1'b1, OFS_IRQ_ENABLE, 32'h3);
		ev(3'h2);
		c1("irq", 1'b0, irq);
		acc(1'b1, OFS_IRQ_ENABLE, 32'h7);
		c1("irq", 1'b1, irq);
		c1("run", 1'b0, run_stop_control);
		c1("halted", 1'b1, halted);
		acc(1'b1, OFS_IRQ_CLEAR, 32'h7);
		ev(3'h4);
		repeat (110) @(posedge core_clk);
		rc("status", OFS_IRQ_STATUS, 32'h00010000);
		repeat (16) @(posedge core_clk);
		rc("status", OFS_IRQ_STATUS, 32'h00010002);
		c1("irq", 1'b1, irq);
		sg_present <= 1'b0;
		repeat (2) @(posedge core_clk);
		c1("irq", 1'b0, irq);
		c1("ignore", 1'b0, ignore_completed);
		acc(1'b1, OFS_IRQ_CLEAR, 32'h7);
		ev(3'h5);
		rc("status", OFS_IRQ_STATUS, 32'h00010000);
		ev(3'h1);
		rc("status", OFS_IRQ_STATUS, 32'h00010001);
		finish_test;
	end
endmodule
bind s2m_channel_ctrl s2m_channel_ctrl_sva u_s2m_channel_ctrl_sva (
	.core_clk(core_clk),
	.rst(rst),
	.avs_read(avs_read),
	.avs_write(avs_write),
	.avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest),
	.sg_present(sg_present),
	.multichannel_mode(multichannel_mode),
	.req_len(req_len),
	.wr_burst(wr_burst),
	.wr_len(wr_len),
	.run_stop_control(run_stop_control),
	.halted(halted),
	.ignore_completed(ignore_completed)
);
`default_nettype wire
